/* File: logic/ifasr_capture.sv */
// Holding register loaded from a received packet field
// Assumes load pulses and data come from logic on the same clock
`timescale 1ns/1ps
module ifasr_capture
   import ifasr_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic clk_sys,
   input wire logic rstSync_n,
   input wire logic load,
   input wire logic [WIDTH-1:0] dataIn,
   output logic [WIDTH-1:0] dataOut
);

   // ==========================================================
   // Capture
   always_ff @(posedge clk_sys or negedge rstSync_n)
   begin
      if (!rstSync_n)
      begin
         dataOut <= '0;
      end
      else if (load)
      begin
         dataOut <= dataIn;
      end
   end

endmodule : ifasr_capture

/* File: logic/ifasr_pkg.sv */
// Constants and carrier types for the packet status register bank
// Assumes a byte-wide register port and packet fields on the system clock
package ifasr_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_PKT_DETECTED = 8'h5A;
   localparam logic [7:0] ADDR_WORD_LENGTH = 8'h62;
   localparam logic [7:0] ADDR_TS_HIGH = 8'h7B;
   localparam logic [7:0] ADDR_TS_MID = 8'h7C;
   localparam logic [7:0] ADDR_TS_LOW_N_HIGH = 8'h7D;
   localparam logic [7:0] ADDR_N_MID = 8'h7E;
   localparam logic [7:0] ADDR_N_LOW = 8'h7F;
   localparam logic [7:0] ADDR_VI_VERSION = 8'h80;
   localparam logic [7:0] ADDR_VI_FORMAT = 8'h81;
   localparam logic [7:0] ADDR_VI_COLOUR = 8'h82;

   // ==========================================================
   // Field positions and widths
   localparam int PKT_TYPES = 7;
   localparam int WORD_LEN_W = 4;
   localparam int REGEN_W = 20;
   localparam int BYTE_W = 8;
   localparam int PKT_AVI_BIT = 0;
   localparam int TS_HIGH_LSB = 12;
   localparam int TS_MID_LSB = 4;
   localparam int TS_LOW_MSB = 3;
   localparam int N_HIGH_LSB = 16;
   localparam int N_MID_LSB = 8;
   localparam int NIBBLE_W = 4;
   localparam int REGEN_LANES = 5;
   localparam int LANE_IDX_W = 3;
   localparam int FIELD2_W = 2;
   localparam int VI_COLOUR_FMT_LSB = 5;
   localparam int VI_AF_BIT = 4;
   localparam int VI_BAR_LSB = 2;
   localparam int VI_SCAN_LSB = 0;
   localparam int VI_COLORIMETRY_LSB = 6;
   localparam int VI_PIC_ASPECT_LSB = 4;
   localparam int VI_ACT_ASPECT_W = 4;
   localparam logic [3:0] WORD_LEN_PAD = 4'h0;
   localparam logic BIT_ZERO = 1'b0;
   // Colour format [6:5], AF present 4, bars [3:2], scan [1:0]
   localparam logic [7:0] VI_FORMAT_MASK = 8'h7F;

   // ==========================================================
   // Reset values
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [6:0] PKT_NONE = 7'h00;
   localparam logic [3:0] WORD_LEN_UNSPEC = 4'h0;

   // ==========================================================
   // Word length codes
   localparam logic [3:0] WL_16 = 4'h4;
   localparam logic [3:0] WL_24 = 4'hD;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic [19:0] timeStamp;
      logic [19:0] regenValue;
   } ifasr_regen_t;

   typedef struct packed {
      logic [7:0] version;
      logic [7:0] format;
      logic [7:0] colourAspect;
   } ifasr_video_info_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic wrStrobe;
      logic rdStrobe;
   } ifasr_bus_req_t;

endpackage : ifasr_pkg

/* File: logic/ifasr_status_regs.sv */
// Read-only status bank for received audio and video packet fields
// Assumes a packet decoder on clk_sys and a host on the plain register port
// Read data stands for the one cycle after the read strobe, zero otherwise
`timescale 1ns/1ps
module ifasr_status_regs
   import ifasr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire ifasr_bus_req_t busReq,
   output logic [7:0] rdData,
   input wire logic clockLost,
   input wire logic [6:0] pktArrived,
   input wire logic chanStatusStrobe,
   input wire logic [3:0] wordLengthIn,
   input wire logic regenStrobe,
   input wire ifasr_regen_t regenIn,
   input wire ifasr_video_info_t videoInfoIn,
   output logic [6:0] pktDetected
);

   // ==========================================================
   // Reset release
   logic rstMeta_reg;
   logic rstSync_reg;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end
      else
      begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end

   // ==========================================================
   // Packet detected flags
   logic [6:0] pktDetected_reg;
   logic [6:0] pktDetected_next;

   genvar gi;
   generate
      for (gi = 0; gi < PKT_TYPES; gi++)
      begin : g_pkt
         always_comb
         begin
            if (pktArrived[gi])
            begin
               pktDetected_next[gi] = 1'b1;
            end
            else if (clockLost)
            begin
               pktDetected_next[gi] = 1'b0;
            end
            else
            begin
               pktDetected_next[gi] = pktDetected_reg[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rstSync_reg)
   begin
      if (!rstSync_reg)
      begin
         pktDetected_reg <= PKT_NONE;
      end
      else
      begin
         pktDetected_reg <= pktDetected_next;
      end
   end

   assign pktDetected = pktDetected_reg;

   // ==========================================================
   // Field captures
   logic [3:0] wordLength_reg;
   logic [REGEN_W-1:0] timeStamp_reg;
   logic [REGEN_W-1:0] regenValue_reg;
   logic [7:0] viVersion_reg;
   logic [7:0] viFormat_reg;
   logic [7:0] viColour_reg;
   logic viLoad;

   assign viLoad = pktArrived[PKT_AVI_BIT];

   ifasr_capture #(.WIDTH(WORD_LEN_W)) u_word_length
   (
      .clk_sys(clk_sys),
      .rstSync_n(rstSync_reg),
      .load(chanStatusStrobe),
      .dataIn(wordLengthIn),
      .dataOut(wordLength_reg)
   );

   ifasr_capture #(.WIDTH(REGEN_W)) u_time_stamp
   (
      .clk_sys(clk_sys),
      .rstSync_n(rstSync_reg),
      .load(regenStrobe),
      .dataIn(regenIn.timeStamp),
      .dataOut(timeStamp_reg)
   );

   ifasr_capture #(.WIDTH(REGEN_W)) u_regen_value
   (
      .clk_sys(clk_sys),
      .rstSync_n(rstSync_reg),
      .load(regenStrobe),
      .dataIn(regenIn.regenValue),
      .dataOut(regenValue_reg)
   );

   ifasr_capture #(.WIDTH(BYTE_W)) u_vi_version
   (
      .clk_sys(clk_sys),
      .rstSync_n(rstSync_reg),
      .load(viLoad),
      .dataIn(videoInfoIn.version),
      .dataOut(viVersion_reg)
   );

   ifasr_capture #(.WIDTH(BYTE_W)) u_vi_format
   (
      .clk_sys(clk_sys),
      .rstSync_n(rstSync_reg),
      .load(viLoad),
      .dataIn(videoInfoIn.format),
      .dataOut(viFormat_reg)
   );

   ifasr_capture #(.WIDTH(BYTE_W)) u_vi_colour
   (
      .clk_sys(clk_sys),
      .rstSync_n(rstSync_reg),
      .load(viLoad),
      .dataIn(videoInfoIn.colourAspect),
      .dataOut(viColour_reg)
   );

   // ==========================================================
   // Video information fields
   logic [1:0] colourFormat;
   logic afPresent;
   logic [1:0] barInfo;
   logic [1:0] scanInfo;
   logic [1:0] colorimetry;
   logic [1:0] pictureAspect;
   logic [3:0] activeAspect;

   always_comb
   begin
      colourFormat = viFormat_reg[VI_COLOUR_FMT_LSB +: FIELD2_W];
   end

   always_comb
   begin
      afPresent = viFormat_reg[VI_AF_BIT];
   end

   always_comb
   begin
      barInfo = viFormat_reg[VI_BAR_LSB +: FIELD2_W];
   end

   always_comb
   begin
      scanInfo = viFormat_reg[VI_SCAN_LSB +: FIELD2_W];
   end

   always_comb
   begin
      colorimetry = viColour_reg[VI_COLORIMETRY_LSB +: FIELD2_W];
   end

   always_comb
   begin
      pictureAspect = viColour_reg[VI_PIC_ASPECT_LSB +: FIELD2_W];
   end

   always_comb
   begin
      activeAspect = viColour_reg[VI_ACT_ASPECT_W-1:0];
   end

   // ==========================================================
   // Location views
   logic [7:0] pktView;
   logic [7:0] wordLengthView;
   logic [7:0] versionView;
   logic [7:0] formatView;
   logic [7:0] colourView;

   always_comb
   begin
      pktView = {BIT_ZERO, pktDetected_reg};
   end

   always_comb
   begin
      wordLengthView = {WORD_LEN_PAD, wordLength_reg};
   end

   always_comb
   begin
      versionView = viVersion_reg;
   end

   // Bit 7 of the format byte reads zero
   always_comb
   begin
      formatView = {BIT_ZERO, colourFormat, afPresent, barInfo, scanInfo};
   end

   always_comb
   begin
      colourView = {colorimetry, pictureAspect, activeAspect};
   end

   // ==========================================================
   // Regeneration byte lanes, most significant lane first
   logic [2*REGEN_W-1:0] regenWord;
   logic [7:0] regenLane [REGEN_LANES];
   logic [7:0] laneOffset;
   logic [LANE_IDX_W-1:0] laneIndex;

   assign regenWord = {timeStamp_reg, regenValue_reg};
   assign laneOffset = busReq.addr - ADDR_TS_HIGH;
   assign laneIndex = laneOffset[LANE_IDX_W-1:0];

   genvar gl;
   generate
      for (gl = 0; gl < REGEN_LANES; gl++)
      begin : g_lane
         assign regenLane[gl] = regenWord[(REGEN_LANES-1-gl)*BYTE_W +: BYTE_W];
      end
   endgenerate

   // ==========================================================
   // Read port
   logic [7:0] rdData_reg;
   logic [7:0] rdData_next;

   always_comb
   begin
      rdData_next = BYTE_ZERO;
      case (busReq.addr)
         ADDR_PKT_DETECTED: rdData_next = pktView;
         ADDR_WORD_LENGTH: rdData_next = wordLengthView;
         ADDR_TS_HIGH,
         ADDR_TS_MID,
         ADDR_TS_LOW_N_HIGH,
         ADDR_N_MID,
         ADDR_N_LOW:
         begin
            rdData_next = regenLane[laneIndex];
         end
         ADDR_VI_VERSION: rdData_next = versionView;
         ADDR_VI_FORMAT: rdData_next = formatView;
         ADDR_VI_COLOUR: rdData_next = colourView;
         default: rdData_next = BYTE_ZERO;
      endcase
   end

   // Writes are never decoded; reads change no state
   always_ff @(posedge clk_sys or negedge rstSync_reg)
   begin
      if (!rstSync_reg)
      begin
         rdData_reg <= BYTE_ZERO;
      end
      else if (busReq.rdStrobe)
      begin
         rdData_reg <= rdData_next;
      end
      else
      begin
         rdData_reg <= BYTE_ZERO;
      end
   end

   assign rdData = rdData_reg;

endmodule : ifasr_status_regs

/* File: testbench/ifasr_status_regs_checker.sv */
// Assertions for the packet status register bank
// Assumes binding to ifasr_status_regs, one clk_sys domain
`timescale 1ns/1ps
module ifasr_status_regs_checker
   import ifasr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire ifasr_bus_req_t busReq,
   input wire logic [7:0] rdData,
   input wire logic clockLost,
   input wire logic [6:0] pktArrived,
   input wire logic chanStatusStrobe,
   input wire logic [3:0] wordLengthIn,
   input wire logic regenStrobe,
   input wire ifasr_regen_t regenIn,
   input wire ifasr_video_info_t videoInfoIn,
   input wire logic [6:0] pktDetected
);
   // ==========
   // Settle count
   logic [1:0] upCnt_reg;
   logic ok;
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         upCnt_reg <= 2'h0;
      else if (upCnt_reg != 2'h3)
         upCnt_reg <= upCnt_reg + 2'h1;
   end
   assign ok = upCnt_reg == 2'h3;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence rdAt(logic [7:0] a);
      busReq.rdStrobe && busReq.addr == a;
   endsequence
   // ==========
   // Properties
   AST_TS_MID: assert property (ok && regenStrobe ##1 rdAt(ADDR_TS_MID)
      |=> rdData == $past(regenIn.timeStamp[11:4], 2)) else $error("ts mid");
   AST_TS_N: assert property (ok && regenStrobe ##1 rdAt(ADDR_TS_LOW_N_HIGH)
      |=> rdData == {$past(regenIn.timeStamp[3:0], 2), $past(regenIn.regenValue[19:16], 2)})
      else $error("ts low n high");
   AST_WORD_LEN: assert property (ok && chanStatusStrobe ##1 rdAt(ADDR_WORD_LENGTH)
      |=> rdData == {4'h0, $past(wordLengthIn, 2)}) else $error("word length");
   AST_VI_FORMAT: assert property (ok && pktArrived[0] ##1 rdAt(ADDR_VI_FORMAT)
      |=> rdData == {1'b0, $past(videoInfoIn.format[6:0], 2)}) else $error("format");
   AST_VI_COLOUR: assert property (ok && pktArrived[0] ##1 rdAt(ADDR_VI_COLOUR)
      |=> rdData == $past(videoInfoIn.colourAspect, 2)) else $error("colour");
   AST_PKT_SET: assert property (ok && |pktArrived
      |=> (pktDetected & $past(pktArrived)) == $past(pktArrived)) else $error("pkt set");
   AST_PKT_CLEAR: assert property (ok && clockLost && pktArrived == 7'h00
      |=> pktDetected == 7'h00) else $error("pkt clear");
   AST_PKT_HOLD: assert property (ok && !clockLost && pktArrived == 7'h00
      |=> $stable(pktDetected)) else $error("pkt hold");
   AST_RD_IDLE: assert property (!busReq.rdStrobe |=> rdData == 8'h00)
      else $error("rd idle");
   CVR_TS: cover property (ok && regenStrobe ##1 rdAt(ADDR_TS_LOW_N_HIGH));
   CVR_LOST: cover property (clockLost && |pktDetected);
   CVR_WR: cover property (busReq.wrStrobe);
endmodule : ifasr_status_regs_checker
bind ifasr_status_regs ifasr_status_regs_checker u_chk (.clk_sys(clk_sys), .nrst(nrst),
   .busReq(busReq), .rdData(rdData), .clockLost(clockLost), .pktArrived(pktArrived),
   .chanStatusStrobe(chanStatusStrobe), .wordLengthIn(wordLengthIn),
   .regenStrobe(regenStrobe), .regenIn(regenIn), .videoInfoIn(videoInfoIn),
   .pktDetected(pktDetected));

/* File: testbench/ifasr_status_regs_tb.sv */
// Self-checking bench for the packet status register bank
// Assumes the bench alone drives every port of ifasr_status_regs
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module ifasr_status_regs_tb
   import ifasr_pkg::*;
;
   logic clk_sys = 1'b0, nrst = 1'b0, clockLost = 1'b0, chanStatusStrobe = 1'b0;
   logic regenStrobe = 1'b0, rdSeen = 1'b0;
   ifasr_bus_req_t busReq = '0;
   ifasr_regen_t regenIn = '0, x = '0;
   ifasr_video_info_t videoInfoIn = '0, v = '0;
   logic [6:0] pktArrived = 7'h00, pktExp = 7'h00, pktDetected;
   logic [3:0] wordLengthIn = 4'h0, wl = 4'h0;
   logic [7:0] rdData, expV, expQ[$];
   logic [31:0] r;
   logic [7:0] addrs [11] = '{ADDR_PKT_DETECTED, ADDR_WORD_LENGTH, ADDR_TS_HIGH, ADDR_TS_MID,
      ADDR_TS_LOW_N_HIGH, ADDR_N_MID, ADDR_N_LOW, ADDR_VI_VERSION, ADDR_VI_FORMAT,
      ADDR_VI_COLOUR, 8'h63};
   int checked = 0, miscompares = 0;
   integer seed = 32'h69b42b91;
   initial forever #20 clk_sys = ~clk_sys;
   ifasr_status_regs u_ifasr_status_regs (.clk_sys(clk_sys), .nrst(nrst), .busReq(busReq),
      .rdData(rdData), .clockLost(clockLost), .pktArrived(pktArrived),
      .chanStatusStrobe(chanStatusStrobe), .wordLengthIn(wordLengthIn),
      .regenStrobe(regenStrobe), .regenIn(regenIn), .videoInfoIn(videoInfoIn),
      .pktDetected(pktDetected));
   // ==========
   // Expected register contents
   function automatic logic [7:0] model(input logic [7:0] a);
      case (a)
         ADDR_PKT_DETECTED: return {1'b0, pktExp};
         ADDR_WORD_LENGTH: return {4'h0, wl};
         ADDR_TS_HIGH: return x.timeStamp[19:12];
         ADDR_TS_MID: return x.timeStamp[11:4];
         ADDR_TS_LOW_N_HIGH: return {x.timeStamp[3:0], x.regenValue[19:16]};
         ADDR_N_MID: return x.regenValue[15:8];
         ADDR_N_LOW: return x.regenValue[7:0];
         ADDR_VI_VERSION: return v.version;
         ADDR_VI_FORMAT: return {1'b0, v.format[6:0]};
         ADDR_VI_COLOUR: return v.colourAspect;
         default: return 8'h00;
      endcase
   endfunction : model
   // ==========
   // Drive one cycle of the bus request, packet arrival, clock-lost and strobe inputs
   task drv(input logic rs, ws, input logic [7:0] a, d, input logic [6:0] arr,
      input logic cl, st);
      @(posedge clk_sys);
      busReq <= '{a, d, ws, rs};
      pktArrived <= arr;
      clockLost <= cl;
      regenStrobe <= st;
      chanStatusStrobe <= st;
      if (rs)
         expQ.push_back(model(a));
      pktExp = (cl ? 7'h00 : pktExp) | arr;
   endtask : drv
   task summarize;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   // ==========
   // Read data watcher
   always @(posedge clk_sys) rdSeen <= busReq.rdStrobe;
   always @(negedge clk_sys)
   begin
      if (rdSeen)
      begin
         expV = expQ.pop_front();
         `CHK("rdData", expV, rdData)
      end
   end
   initial
   begin
      repeat (4000) @(posedge clk_sys);
      miscompares++;
      summarize();
   end
   // ==========
   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      for (int k = 0; k < 11; k++)
         drv(1'b1, 1'b0, addrs[k], 8'h00, 7'h00, 1'b0, 1'b0);
      for (int i = 0; i < 16; i++)
      begin
         r = $random(seed);
         x = {r[19:0], ~r[31:12]};
         v = {r[7:0], r[31], i[1:0], i[0], i[3:2], i[1:0], i[1:0], r[13:8]};
         wl = i[3:0];
         regenIn <= x;
         videoInfoIn <= v;
         wordLengthIn <= wl;
         drv(1'b0, 1'b0, 8'h00, 8'h00, r[26:20] | 7'h01, i % 4 == 3, 1'b1);
         drv(1'b0, 1'b1, addrs[i % 11], ~r[7:0], 7'h00, 1'b0, 1'b0);
         for (int k = 0; k < 11; k++)
            drv(1'b1, 1'b0, addrs[(i + k) % 11], 8'h00, 7'h00, 1'b0, 1'b0);
         drv(1'b0, 1'b0, 8'h00, 8'h00, 7'h00, i % 4 == 1, 1'b0);
         drv(1'b0, 1'b0, 8'h00, 8'h00, 7'h00, 1'b0, 1'b0);
         @(negedge clk_sys);
         `CHK("pktDetected", pktExp, pktDetected)
      end
      // Mid-run reset, every location back to zero
      @(posedge clk_sys);
      nrst <= 1'b0;
      x = '0;
      v = '0;
      wl = 4'h0;
      pktExp = 7'h00;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      for (int k = 0; k < 11; k++)
         drv(1'b1, 1'b0, addrs[k], 8'h00, 7'h00, 1'b0, 1'b0);
      repeat (3) @(posedge clk_sys);
      summarize();
   end
endmodule : ifasr_status_regs_tb
